// ---- src/scmc_map.svh ----
`ifndef SCMC_MAP_SVH
`define SCMC_MAP_SVH

// ****************************************
// register offsets and fields
// ****************************************
`define SCMC_ADDR_W 4
`define SCMC_OFS_SYSCLK_SEL 4'h0
`define SCMC_OFS_FAST_OSC 4'h1
`define SCMC_SEL_HI 7
`define SCMC_SEL_LO 5
`define SCMC_FAST_KEEP_BIT 1
`define SCMC_SLOW_KEEP_BIT 0
`define SCMC_STABLE_BIT 1
`define SCMC_ENABLE_BIT 0
`define SCMC_SEL_SLOW 3'h7
`define SCMC_SEL_RST 3'h0
`define SCMC_KEEP_RST 1'h0
`define SCMC_ENABLE_RST 1'h1
`define SCMC_STABLE_RST 1'h0

// ****************************************
// timing
// ****************************************
// cycles the synced ready level must hold before the flag sets
`define SCMC_SETTLE_CYC 8'h04
`define SCMC_DIV_W 6

`endif

// ---- src/scmc_pkg.sv ----
package scmc_pkg;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    MODE_FAST,
    MODE_SLOW,
    MODE_SLEEP,
    MODE_IDLE_SLOW_ONLY,
    MODE_IDLE_BOTH_CLOCKS,
    MODE_IDLE_FAST_ONLY
  } scmc_mode_e;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_IDLE_SLOW_ONLY,
    ST_IDLE_BOTH_CLOCKS,
    ST_IDLE_FAST_ONLY
  } scmc_state_e;

  // register port request from the cpu
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scmc_bus_req_s;

  // run enables toward the clock tree
  typedef struct packed {
    logic cpu_run;
    logic fast_osc_run;
    logic slow_clk_run;
    logic slow_osc_run;
    logic sysclk_run;
  } scmc_clk_ctrl_s;

endpackage : scmc_pkg

// ---- src/scmc_top.sv ----
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "scmc_map.svh"

module scmc_top #(
  parameter int unsigned DIV_W = `SCMC_DIV_W,
  parameter logic [7:0] SETTLE_CYC = `SCMC_SETTLE_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire scmc_pkg::scmc_bus_req_s bus_i,
  output logic [7:0] rdata_o,
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic watchdog_en_i,
  input wire logic fast_osc_ready_i,
  input wire logic slow_osc_raw_clock_i,
  output scmc_pkg::scmc_clk_ctrl_s clk_ctrl_o,
  output scmc_pkg::scmc_mode_e mode_o,
  output logic sysclk_tick_o
);

  // ****************************************
  // helpers
  // ****************************************
  // mask of divider bits that must be all ones for a tick
  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
    logic [DIV_W:0] one;
    one = {{DIV_W{1'b0}}, 1'b1};
    div_mask = DIV_W'((one << sel) - one);
  endfunction : div_mask

  // ****************************************
  // registers
  // ****************************************
  logic [2:0] sel_reg;
  logic fast_keep_reg;
  logic slow_keep_reg;
  logic fast_en_reg;
  logic stable_reg;
  logic [7:0] settle_cnt_reg;
  logic [7:0] rdata_reg;
  scmc_pkg::scmc_state_e state_reg;
  scmc_pkg::scmc_state_e state_next;
  scmc_pkg::scmc_clk_ctrl_s ctrl_reg;
  scmc_pkg::scmc_clk_ctrl_s ctrl_next;
  scmc_pkg::scmc_mode_e mode_reg;
  scmc_pkg::scmc_mode_e mode_next;
  logic [DIV_W-1:0] div_cnt_reg;
  logic tick_reg;
  logic tick_next;
  logic [2:0] rdy_sync_reg;
  logic rdy_lvl_reg;
  logic [2:0] slo_sync_reg;
  logic slo_lvl_reg;
  logic slow_rise;
  logic wr_sel;
  logic wr_fast;
  logic fast_sel;

  assign wr_sel = bus_i.wr && (bus_i.addr == `SCMC_OFS_SYSCLK_SEL);
  assign wr_fast = bus_i.wr && (bus_i.addr == `SCMC_OFS_FAST_OSC);
  assign fast_sel = (sel_reg != `SCMC_SEL_SLOW);

  // ****************************************
  // pin synchronisers
  // ****************************************
  // three stages; a level only moves once stages two and three agree
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rdy_sync_reg <= 3'h0;
      rdy_lvl_reg <= 1'b0;
    end
    else
    begin
      rdy_sync_reg <= {rdy_sync_reg[1:0], fast_osc_ready_i};
      if (rdy_sync_reg[1] == rdy_sync_reg[2])
        rdy_lvl_reg <= rdy_sync_reg[2];
    end
  end

  // slow oscillator edges, used as the slow clock tick
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      slo_sync_reg <= 3'h0;
      slo_lvl_reg <= 1'b0;
    end
    else
    begin
      slo_sync_reg <= {slo_sync_reg[1:0], slow_osc_raw_clock_i};
      if (slo_sync_reg[1] == slo_sync_reg[2])
        slo_lvl_reg <= slo_sync_reg[2];
    end
  end

  assign slow_rise = (slo_sync_reg[1] == slo_sync_reg[2]) && slo_sync_reg[2] && !slo_lvl_reg;

  // ****************************************
  // software registers
  // ****************************************
  // select and keep-alive bits; select may change in any state
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sel_reg <= `SCMC_SEL_RST;
      fast_keep_reg <= `SCMC_KEEP_RST;
      slow_keep_reg <= `SCMC_KEEP_RST;
    end
    else if (wr_sel)
    begin
      sel_reg <= bus_i.wdata[`SCMC_SEL_HI:`SCMC_SEL_LO];
      fast_keep_reg <= bus_i.wdata[`SCMC_FAST_KEEP_BIT];
      slow_keep_reg <= bus_i.wdata[`SCMC_SLOW_KEEP_BIT];
    end
  end

  // fast oscillator enable, on after reset
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      fast_en_reg <= `SCMC_ENABLE_RST;
    else if (wr_fast)
      fast_en_reg <= bus_i.wdata[`SCMC_ENABLE_BIT];
  end

  // stable flag: the enable write clears it and restarts the settle count, so a ready
  // level still high from before sets it again once the count reaches SETTLE_CYC
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      stable_reg <= `SCMC_STABLE_RST;
      settle_cnt_reg <= 8'h00;
    end
    else if ((wr_fast && bus_i.wdata[`SCMC_ENABLE_BIT]) || !ctrl_reg.fast_osc_run
             || !rdy_lvl_reg)
    begin
      stable_reg <= 1'b0;
      settle_cnt_reg <= 8'h00;
    end
    else if (settle_cnt_reg == SETTLE_CYC)
      stable_reg <= 1'b1;
    else
      settle_cnt_reg <= settle_cnt_reg + 8'h01;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rdata_reg <= 8'h00;
    else if (bus_i.rd && bus_i.addr == `SCMC_OFS_SYSCLK_SEL)
      rdata_reg <= {sel_reg, 3'h0, fast_keep_reg, slow_keep_reg};
    else if (bus_i.rd && bus_i.addr == `SCMC_OFS_FAST_OSC)
      rdata_reg <= {6'h00, stable_reg, fast_en_reg};
    else
      rdata_reg <= 8'h00;
  end

  assign rdata_o = rdata_reg;

  // ****************************************
  // halt state machine
  // ****************************************
  // only a halt pulse leaves run; wake wins over a late halt
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      scmc_pkg::ST_RUN:
      begin
        if (halt_i)
        begin
          case ({fast_keep_reg, slow_keep_reg})
            2'b00: state_next = scmc_pkg::ST_SLEEP;
            2'b01: state_next = scmc_pkg::ST_IDLE_SLOW_ONLY;
            2'b11: state_next = scmc_pkg::ST_IDLE_BOTH_CLOCKS;
            default: state_next = scmc_pkg::ST_IDLE_FAST_ONLY;
          endcase
        end
      end
      scmc_pkg::ST_SLEEP,
      scmc_pkg::ST_IDLE_SLOW_ONLY,
      scmc_pkg::ST_IDLE_BOTH_CLOCKS,
      scmc_pkg::ST_IDLE_FAST_ONLY:
      begin
        if (wake_i)
          state_next = scmc_pkg::ST_RUN;
      end
      default: state_next = scmc_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      state_reg <= scmc_pkg::ST_RUN;
    else
      state_reg <= state_next;
  end

  // ****************************************
  // clock enables
  // ****************************************
  // decoded from the current state; registered toward the clock tree
  always_comb
  begin
    ctrl_next = '0;
    mode_next = scmc_pkg::MODE_FAST;
    case (state_reg)
      scmc_pkg::ST_RUN:
      begin
        ctrl_next.cpu_run = 1'b1;
        ctrl_next.slow_clk_run = 1'b1;
        ctrl_next.slow_osc_run = 1'b1;
        ctrl_next.sysclk_run = 1'b1;
        if (fast_sel)
        begin
          ctrl_next.fast_osc_run = 1'b1;
          mode_next = scmc_pkg::MODE_FAST;
        end
        else
        begin
          ctrl_next.fast_osc_run = fast_en_reg;
          mode_next = scmc_pkg::MODE_SLOW;
        end
      end
      scmc_pkg::ST_SLEEP:
      begin
        ctrl_next.slow_osc_run = watchdog_en_i;
        mode_next = scmc_pkg::MODE_SLEEP;
      end
      scmc_pkg::ST_IDLE_SLOW_ONLY:
      begin
        ctrl_next.slow_clk_run = 1'b1;
        ctrl_next.slow_osc_run = 1'b1;
        ctrl_next.sysclk_run = !fast_sel;
        mode_next = scmc_pkg::MODE_IDLE_SLOW_ONLY;
      end
      scmc_pkg::ST_IDLE_BOTH_CLOCKS:
      begin
        ctrl_next.fast_osc_run = 1'b1;
        ctrl_next.slow_clk_run = 1'b1;
        ctrl_next.slow_osc_run = 1'b1;
        ctrl_next.sysclk_run = 1'b1;
        mode_next = scmc_pkg::MODE_IDLE_BOTH_CLOCKS;
      end
      scmc_pkg::ST_IDLE_FAST_ONLY:
      begin
        ctrl_next.fast_osc_run = 1'b1;
        ctrl_next.slow_osc_run = 1'b1;
        ctrl_next.sysclk_run = fast_sel;
        mode_next = scmc_pkg::MODE_IDLE_FAST_ONLY;
      end
      default:
      begin
        ctrl_next = '0;
        mode_next = scmc_pkg::MODE_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_reg <= '0;
      mode_reg <= scmc_pkg::MODE_FAST;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      mode_reg <= mode_next;
    end
  end

  assign clk_ctrl_o = ctrl_reg;
  assign mode_o = mode_reg;

  // ****************************************
  // system clock divider
  // ****************************************
  // clk_i stands in for the fast clock; the divider halts with it
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      div_cnt_reg <= '0;
    else if (ctrl_next.fast_osc_run)
      div_cnt_reg <= div_cnt_reg + DIV_W'(1);
  end

  // tick of the selected system clock, gated by the run enable
  always_comb
  begin
    tick_next = 1'b0;
    if (ctrl_next.sysclk_run)
    begin
      if (fast_sel)
        tick_next = ctrl_next.fast_osc_run &&
                    ((div_cnt_reg & div_mask(sel_reg)) == div_mask(sel_reg));
      else
        tick_next = slow_rise;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      tick_reg <= 1'b0;
    else
      tick_reg <= tick_next;
  end

  assign sysclk_tick_o = tick_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  sequence halt_with(logic [1:0] keep);
    state_reg == scmc_pkg::ST_RUN && halt_i && {fast_keep_reg, slow_keep_reg} == keep;
  endsequence

  sleep_entry_a: assert property (halt_with(2'b00) |=> ##1 (!clk_ctrl_o.cpu_run
    && mode_o == scmc_pkg::MODE_SLEEP && !clk_ctrl_o.fast_osc_run && !clk_ctrl_o.sysclk_run))
    else $error("sleep entry wrong");
  idle_slow_entry_a: assert property (halt_with(2'b01) |=> ##1 (!clk_ctrl_o.cpu_run
    && !clk_ctrl_o.fast_osc_run && clk_ctrl_o.slow_clk_run))
    else $error("idle slow-only entry wrong");
  idle_both_entry_a: assert property (halt_with(2'b11) |=> ##1 (!clk_ctrl_o.cpu_run
    && clk_ctrl_o.fast_osc_run && clk_ctrl_o.sysclk_run))
    else $error("idle both-clocks entry wrong");
  idle_fast_entry_a: assert property (halt_with(2'b10) |=> ##1 (!clk_ctrl_o.cpu_run
    && clk_ctrl_o.fast_osc_run && !clk_ctrl_o.slow_clk_run))
    else $error("idle fast-only entry wrong");
  sleep_watchdog_a: assert property (state_reg == scmc_pkg::ST_SLEEP |=>
    clk_ctrl_o.slow_osc_run == $past(watchdog_en_i))
    else $error("slow oscillator not following watchdog in sleep");
  idle_sysclk_a: assert property ((state_reg == scmc_pkg::ST_IDLE_SLOW_ONLY ||
    state_reg == scmc_pkg::ST_IDLE_FAST_ONLY) |=> clk_ctrl_o.sysclk_run ==
    ($past(state_reg == scmc_pkg::ST_IDLE_SLOW_ONLY) ^ $past(fast_sel)))
    else $error("idle system clock gating wrong");
  slow_fast_en_a: assert property ((state_reg == scmc_pkg::ST_RUN && !fast_sel) |=>
    (clk_ctrl_o.fast_osc_run == $past(fast_en_reg) && mode_o == scmc_pkg::MODE_SLOW))
    else $error("slow mode fast oscillator wrong");
  fast_div_one_a: assert property ((state_reg == scmc_pkg::ST_RUN && sel_reg == 3'h0)
    [*2] |=> sysclk_tick_o)
    else $error("undivided fast tick missing");
  unimpl_zero_a: assert property (bus_i.rd |=> rdata_o[4:2] == 3'h0 &&
    ($past(bus_i.addr) != `SCMC_OFS_FAST_OSC || rdata_o[7:2] == 6'h00))
    else $error("unimplemented bits read nonzero");
  stable_clear_a: assert property (wr_fast && bus_i.wdata[`SCMC_ENABLE_BIT] |=>
    !stable_reg ##1 !stable_reg)
    else $error("stable flag not cleared on enable");
  no_spurious_halt_a: assert property (state_reg == scmc_pkg::ST_RUN && !halt_i |=>
    state_reg == scmc_pkg::ST_RUN)
    else $error("halted without halt instruction");
  keep_bits_a: assert property (wr_sel |=>
    fast_keep_reg == $past(bus_i.wdata[1]) && slow_keep_reg == $past(bus_i.wdata[0]))
    else $error("keep-alive bits not stored");

endmodule : scmc_top

// ---- verification/tb_scmc_top.sv ----
`timescale 1ns/1ps
`include "scmc_map.svh"

module tb_scmc_top;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  scmc_pkg::scmc_bus_req_s bus_i = '0;
  logic halt_i = 1'b0;
  logic wake_i = 1'b0;
  logic watchdog_en_i = 1'b0;
  logic fast_osc_ready_i = 1'b0;
  logic slow_osc_raw_clock_i = 1'b0;
  logic [7:0] rdata_o;
  scmc_pkg::scmc_clk_ctrl_s clk_ctrl_o;
  scmc_pkg::scmc_mode_e mode_o;
  logic sysclk_tick_o;
  int fails = 0;
  int compares = 0;

  // halted mode per keep-alive pair, index {fast, slow}
  scmc_pkg::scmc_mode_e mode_tab [4] = '{scmc_pkg::MODE_SLEEP,
    scmc_pkg::MODE_IDLE_SLOW_ONLY, scmc_pkg::MODE_IDLE_FAST_ONLY,
    scmc_pkg::MODE_IDLE_BOTH_CLOCKS};

  // 40 mhz clock
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end

  scmc_top #(
    .DIV_W(6),
    .SETTLE_CYC(8'h04)
  ) scmc_top_i (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .bus_i(bus_i),
    .rdata_o(rdata_o),
    .halt_i(halt_i),
    .wake_i(wake_i),
    .watchdog_en_i(watchdog_en_i),
    .fast_osc_ready_i(fast_osc_ready_i),
    .slow_osc_raw_clock_i(slow_osc_raw_clock_i),
    .clk_ctrl_o(clk_ctrl_o),
    .mode_o(mode_o),
    .sysclk_tick_o(sysclk_tick_o)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic summarize();
    if (fails == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // case equality so an unknown never passes
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : chk

  task automatic chkb(input string name, input logic exp, input logic got);
    chk(name, {7'h00, exp}, {7'h00, got});
  endtask : chkb

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.wdata <= d;
    bus_i.wr <= 1'b1;
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1;
    chk(name, exp, rdata_o);
    // the data must not linger past its one cycle
    @(posedge clk_i);
    #1;
    chk("read data drop", 8'h00, rdata_o);
  endtask : rd

  // halt or wake pulse, then let the two-edge decode settle
  task automatic strobe(input logic is_halt);
    @(posedge clk_i);
    halt_i <= is_halt;
    wake_i <= ~is_halt;
    @(posedge clk_i);
    halt_i <= 1'b0;
    wake_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : strobe

  // sampled at the falling edge so each one-cycle pulse counts once
  task automatic ticks(input int n, output int c);
    c = 0;
    repeat (n)
    begin
      @(negedge clk_i);
      if (sysclk_tick_o === 1'b1)
        c++;
    end
  endtask : ticks

  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    int c;
    logic [2:0] sel;
    logic sys_exp;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("reset mode", 8'(scmc_pkg::MODE_FAST), 8'(mode_o));
    chkb("reset cpu_run", 1'b1, clk_ctrl_o.cpu_run);
    rd(`SCMC_OFS_SYSCLK_SEL, 8'h00, "sel reg reset");
    rd(`SCMC_OFS_FAST_OSC, 8'h01, "osc reg reset");
    rd(4'h5, 8'h00, "unmapped read");
    // keep-alive bits set while running must not halt anything
    wr(`SCMC_OFS_SYSCLK_SEL, 8'hff);
    rd(`SCMC_OFS_SYSCLK_SEL, 8'he3, "sel reg fields");
    chk("no halt on write", 8'(scmc_pkg::MODE_SLOW), 8'(mode_o));
    @(posedge clk_i);
    fast_osc_ready_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    rd(`SCMC_OFS_FAST_OSC, 8'h03, "stable set");
    wr(`SCMC_OFS_FAST_OSC, 8'hff);
    rd(`SCMC_OFS_FAST_OSC, 8'h01, "stable cleared");
    repeat (20) @(posedge clk_i);
    rd(`SCMC_OFS_FAST_OSC, 8'h03, "stable again");
    // every fast divide code over a window that is a multiple of 64
    for (int n = 0; n < 7; n++)
    begin
      wr(`SCMC_OFS_SYSCLK_SEL, {3'(n), 5'h00});
      repeat (70) @(posedge clk_i);
      ticks(128, c);
      chk("fast ticks", 8'(128 >> n), 8'(c));
      chk("fast mode", 8'(scmc_pkg::MODE_FAST), 8'(mode_o));
    end
    // slow code: one tick per slow oscillator rising edge, window covers sync lag
    wr(`SCMC_OFS_SYSCLK_SEL, 8'he0);
    fork
      repeat (8)
      begin
        repeat (8) @(posedge clk_i);
        slow_osc_raw_clock_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        slow_osc_raw_clock_i <= 1'b0;
      end
      ticks(160, c);
    join
    chk("slow ticks", 8'h08, 8'(c));
    chk("slow mode", 8'(scmc_pkg::MODE_SLOW), 8'(mode_o));
    wr(`SCMC_OFS_FAST_OSC, 8'h00);
    repeat (3) @(posedge clk_i);
    #1;
    chkb("slow fast off", 1'b0, clk_ctrl_o.fast_osc_run);
    wr(`SCMC_OFS_FAST_OSC, 8'h01);
    repeat (3) @(posedge clk_i);
    #1;
    chkb("slow fast on", 1'b1, clk_ctrl_o.fast_osc_run);
    // all keep-alive pairs, each with a fast and the slow select code
    for (int k = 0; k < 8; k++)
    begin
      sel = k[2] ? 3'h7 : 3'h0;
      wr(`SCMC_OFS_SYSCLK_SEL, {sel, 3'h0, k[1], k[0]});
      watchdog_en_i <= k[2];
      strobe(1'b1);
      chk("halt mode", 8'(mode_tab[k[1:0]]), 8'(mode_o));
      chkb("halt cpu_run", 1'b0, clk_ctrl_o.cpu_run);
      chkb("halt fast osc", k[1], clk_ctrl_o.fast_osc_run);
      chkb("halt slow clk", k[0], clk_ctrl_o.slow_clk_run);
      sys_exp = k[1] & k[0] | k[0] & k[2] | k[1] & ~k[2];
      chkb("halt sysclk", sys_exp, clk_ctrl_o.sysclk_run);
      if (k[1:0] == 2'h0)
        chkb("sleep slow osc", k[2], clk_ctrl_o.slow_osc_run);
      // a running fast source ticks every cycle; the slow pin is quiet here
      ticks(32, c);
      chk("gated ticks", 8'((sys_exp && !k[2]) ? 32 : 0), 8'(c));
      // a second halt while halted is ignored
      strobe(1'b1);
      chk("halt ignored", 8'(mode_tab[k[1:0]]), 8'(mode_o));
      strobe(1'b0);
      chk("woken mode", 8'(k[2] ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST),
        8'(mode_o));
      chkb("woken cpu_run", 1'b1, clk_ctrl_o.cpu_run);
    end
    summarize();
  end

  // the tests need about 2000 cycles; cut a hang off well after that
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails++;
    summarize();
  end

endmodule : tb_scmc_top
